// ===== hdl/tlts_pkg.sv
`default_nettype none
package tlts_pkg;
  localparam int WORD_W = 24;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 20;
  localparam logic [3:0] ADDR_OPER = 4'h4;
  localparam logic [3:0] ADDR_SYNTH = 4'h5;
  localparam logic [WORD_W-1:0] OPER_RESET = 24'h000004;
  localparam logic [WORD_W-1:0] SYNTH_RESET = 24'h000005;
  // Address-4 field positions
  localparam int OP_RX_DLL = 23;
  localparam int OP_GAIN_LSB = 14;
  localparam int OP_VTH_LSB = 12;
  localparam int OP_SLOPE_LSB = 10;
  localparam int OP_IMAX_LSB = 8;
  localparam int OP_BAND = 7;
  localparam int OP_EXT_IF = 6;
  localparam int OP_BB_STD = 5;
  localparam int OP_BB_BYPASS = 4;
  // Address-5 field positions
  localparam int SY_UHF_IN = 23;
  localparam int SY_RX_LOW_SIDE = 22;
  localparam int SY_RX_DIV4 = 21;
  localparam int SY_RX_PD_INV = 20;
  localparam int SY_RX_CP_LSB = 18;
  localparam int SY_FRACN_COMP = 17;
  localparam int SY_DOUBLER = 14;
  localparam int SY_DENOM_LSB = 7;
  localparam int SY_UHF_CP_LSB = 4;
  // Fractional-N denominators per code
  localparam logic [4:0] DENOM_0 = 5'h05;
  localparam logic [4:0] DENOM_1 = 5'h08;
  localparam logic [4:0] DENOM_2 = 5'h0d;
  localparam logic [4:0] DENOM_3 = 5'h14;
endpackage
`default_nettype wire

// ===== hdl/tlts_sync.sv
`timescale 1ns/1ns
`default_nettype none
module tlts_sync #(
  parameter int W = 3
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  // First stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // tlts_sync
`default_nettype wire

// ===== hdl/tlts_shift.sv
`timescale 1ns/1ns
`default_nettype none
module tlts_shift
  import tlts_pkg::*;
#(
  parameter int W = 24
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk_s,
  input wire logic sdat_s,
  input wire logic slatch_s,
  output logic [W-1:0] word,
  output logic word_stb
);
  logic sclk_d_r;
  logic slatch_d_r;
  logic [W-1:0] shift_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_d_r <= 1'b0;
      slatch_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      slatch_d_r <= slatch_s;
    end
  end
  // MSB first; data sampled on rising serial clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_r <= '0;
    end else if (sclk_s && !sclk_d_r) begin
      shift_r <= {shift_r[W-2:0], sdat_s};
    end
  end
  // Word taken on latch rising edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      word <= '0;
      word_stb <= 1'b0;
    end else begin
      word_stb <= slatch_s && !slatch_d_r;
      if (slatch_s && !slatch_d_r) begin
        word <= shift_r;
      end
    end
  end
endmodule // tlts_shift
`default_nettype wire

// ===== hdl/tlts_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tlts_regs
  import tlts_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ser_data,
  input wire logic ser_clk,
  input wire logic ser_latch,
  output logic [1:0] tx_gain_code,
  output logic [1:0] tx_vth_code,
  output logic [1:0] tx_slope_code,
  output logic [1:0] tx_imax_code,
  output logic tx_band_1900,
  output logic tx_ext_if_filter,
  output logic tx_bb_bypass,
  output logic tx_bb_std_unused,
  output logic rx_dll_en,
  output logic uhf_doubler_en,
  output logic uhf_in_1900,
  output logic fracn_comp_en,
  output logic [4:0] fracn_denom,
  output logic [1:0] uhf_cp_code,
  output logic rx_lo_low_side,
  output logic rx_lo_div4,
  output logic rx_pd_invert,
  output logic [1:0] rx_cp_code
);
  ////////////////////////////////////////////////////////////////
  logic sdat_s;
  logic sclk_s;
  logic slatch_s;
  logic [WORD_W-1:0] word;
  logic word_stb;
  logic [WORD_W-1:0] oper_r;
  logic [WORD_W-1:0] synth_r;
  logic oper_we;
  logic synth_we;
  logic [1:0] gain_nxt;
  logic [1:0] vth_nxt;
  logic [1:0] slope_nxt;
  logic [1:0] imax_nxt;
  logic band_nxt;
  logic ext_if_nxt;
  logic bb_bypass_nxt;
  logic bb_std_nxt;
  logic dll_nxt;
  logic doubler_nxt;
  logic uhf_in_nxt;
  logic comp_nxt;
  logic [4:0] denom_nxt;
  logic [1:0] uhf_cp_nxt;
  logic low_side_nxt;
  logic div4_nxt;
  logic pd_inv_nxt;
  logic [1:0] rx_cp_nxt;

  tlts_sync #(.W(3)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d({ser_data, ser_clk, ser_latch}),
    .q({sdat_s, sclk_s, slatch_s})
  );

  tlts_shift #(.W(WORD_W)) u_shift (
    .core_clk(core_clk),
    .rst(rst),
    .sclk_s(sclk_s),
    .sdat_s(sdat_s),
    .slatch_s(slatch_s),
    .word(word),
    .word_stb(word_stb)
  );

  ////////////////////////////////////////////////////////////////
  // Other addresses are ignored here; they belong to other banks
  assign oper_we = word_stb && (word[ADDR_W-1:0] == ADDR_OPER);
  assign synth_we = word_stb && (word[ADDR_W-1:0] == ADDR_SYNTH);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      oper_r <= OPER_RESET;
    end else if (oper_we) begin
      oper_r <= word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      synth_r <= SYNTH_RESET;
    end else if (synth_we) begin
      synth_r <= word;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Registered decode keeps outputs glitch free toward analog
  always_comb begin
    gain_nxt = oper_r[OP_GAIN_LSB +: 2];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_gain_code <= 2'h0;
    end else begin
      tx_gain_code <= gain_nxt;
    end
  end

  always_comb begin
    vth_nxt = oper_r[OP_VTH_LSB +: 2];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_vth_code <= 2'h0;
    end else begin
      tx_vth_code <= vth_nxt;
    end
  end

  always_comb begin
    slope_nxt = oper_r[OP_SLOPE_LSB +: 2];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_slope_code <= 2'h0;
    end else begin
      tx_slope_code <= slope_nxt;
    end
  end

  always_comb begin
    imax_nxt = oper_r[OP_IMAX_LSB +: 2];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_imax_code <= 2'h0;
    end else begin
      tx_imax_code <= imax_nxt;
    end
  end

  always_comb begin
    band_nxt = oper_r[OP_BAND];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_band_1900 <= 1'b0;
    end else begin
      tx_band_1900 <= band_nxt;
    end
  end

  always_comb begin
    ext_if_nxt = oper_r[OP_EXT_IF];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_ext_if_filter <= 1'b0;
    end else begin
      tx_ext_if_filter <= ext_if_nxt;
    end
  end

  always_comb begin
    bb_bypass_nxt = oper_r[OP_BB_BYPASS];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_bb_bypass <= 1'b0;
    end else begin
      tx_bb_bypass <= bb_bypass_nxt;
    end
  end

  always_comb begin
    bb_std_nxt = oper_r[OP_BB_STD];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_bb_std_unused <= 1'b0;
    end else begin
      tx_bb_std_unused <= bb_std_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Gated fields follow both registers
  always_comb begin
    // DLL only meaningful with divide-by-two second LO
    dll_nxt = oper_r[OP_RX_DLL] && !synth_r[SY_RX_DIV4];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_dll_en <= 1'b0;
    end else begin
      rx_dll_en <= dll_nxt;
    end
  end

  always_comb begin
    doubler_nxt = synth_r[SY_DOUBLER] && oper_r[OP_BAND];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      uhf_doubler_en <= 1'b0;
    end else begin
      uhf_doubler_en <= doubler_nxt;
    end
  end

  always_comb begin
    uhf_in_nxt = synth_r[SY_UHF_IN] && synth_r[SY_DOUBLER] && oper_r[OP_BAND];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      uhf_in_1900 <= 1'b0;
    end else begin
      uhf_in_1900 <= uhf_in_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Synthesizer and receive LO fields
  always_comb begin
    comp_nxt = synth_r[SY_FRACN_COMP];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fracn_comp_en <= 1'b0;
    end else begin
      fracn_comp_en <= comp_nxt;
    end
  end

  always_comb begin
    case (synth_r[SY_DENOM_LSB +: 2])
      2'h0: denom_nxt = DENOM_0;
      2'h1: denom_nxt = DENOM_1;
      2'h2: denom_nxt = DENOM_2;
      2'h3: denom_nxt = DENOM_3;
      default: denom_nxt = DENOM_0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fracn_denom <= DENOM_0;
    end else begin
      fracn_denom <= denom_nxt;
    end
  end

  always_comb begin
    uhf_cp_nxt = synth_r[SY_UHF_CP_LSB +: 2];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      uhf_cp_code <= 2'h0;
    end else begin
      uhf_cp_code <= uhf_cp_nxt;
    end
  end

  always_comb begin
    low_side_nxt = synth_r[SY_RX_LOW_SIDE];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_lo_low_side <= 1'b0;
    end else begin
      rx_lo_low_side <= low_side_nxt;
    end
  end

  always_comb begin
    div4_nxt = synth_r[SY_RX_DIV4];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_lo_div4 <= 1'b0;
    end else begin
      rx_lo_div4 <= div4_nxt;
    end
  end

  always_comb begin
    pd_inv_nxt = synth_r[SY_RX_PD_INV];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_pd_invert <= 1'b0;
    end else begin
      rx_pd_invert <= pd_inv_nxt;
    end
  end

  always_comb begin
    rx_cp_nxt = synth_r[SY_RX_CP_LSB +: 2];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_cp_code <= 2'h0;
    end else begin
      rx_cp_code <= rx_cp_nxt;
    end
  end
endmodule // tlts_regs
`default_nettype wire

// ===== test/tlts_host.sv
`timescale 1ns/1ns
`default_nettype none
module tlts_host (
  output logic ser_data,
  output logic ser_clk,
  output logic ser_latch
);
  initial begin
    ser_data = 1'b0;
    ser_clk = 1'b0;
    ser_latch = 1'b0;
  end
  // Clock stands still between frames
  task automatic send(input logic [23:0] w);
    for (int k = 23; k >= 0; k--) begin
      ser_data = w[k];
      #40 ser_clk = 1'b1;
      #40 ser_clk = 1'b0;
    end
    #40 ser_latch = 1'b1;
    ser_data = ~w[0];
    #100 ser_latch = 1'b0;
    #40;
  endtask
endmodule // tlts_host
`default_nettype wire

// ===== test/tlts_regs_sva.sv
`timescale 1ns/1ns
`default_nettype none
module tlts_regs_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ser_latch,
  input wire logic [1:0] tx_gain_code,
  input wire logic tx_band_1900,
  input wire logic rx_dll_en,
  input wire logic rx_lo_div4,
  input wire logic uhf_doubler_en,
  input wire logic uhf_in_1900,
  input wire logic [4:0] fracn_denom,
  input wire logic [1:0] uhf_cp_code,
  input wire logic [1:0] rx_cp_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_uhf_gate: assert property (uhf_in_1900 |-> uhf_doubler_en) else $error("uhf input ungated");
  a_dbl_band: assert property (uhf_doubler_en |-> tx_band_1900) else $error("doubler without band");
  a_dll_div: assert property (rx_dll_en |-> !rx_lo_div4) else $error("dll with div4");
  a_denom_ok: assert property (fracn_denom inside {5'h05, 5'h08, 5'h0d, 5'h14}) else $error("bad denom");
  a_rst_vals: assert property ($fell(rst) |-> fracn_denom == 5'h05 && !tx_band_1900) else $error("reset value");
  a_hold_codes: assert property (!$stable({tx_gain_code, rx_cp_code, uhf_cp_code, fracn_denom})
    |-> $past(ser_latch, 3)) else $error("code moved without latch");
  a_hold_band: assert property (!$stable(tx_band_1900) |-> $past(ser_latch, 3)) else $error("band moved");
  a_hold_dll: assert property (!$stable(rx_dll_en) |-> $past(ser_latch, 3)) else $error("dll moved");
  c_dll: cover property (rx_dll_en);
  c_uhf: cover property (uhf_in_1900);
  c_gain: cover property (!$stable(tx_gain_code));
endmodule // tlts_regs_sva
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tlts_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  wire ser_data, ser_clk, ser_latch;
  logic [1:0] g, v, s, i, uc, rc;
  logic band, ext, byp, bbs, dll, dbl, uin, comp, ls, d4, inv;
  logic [4:0] den;
  logic [4:0] dt [4] = '{DENOM_0, DENOM_1, DENOM_2, DENOM_3};
  int mismatches = 0;
  int check_count = 0;
  always #5 core_clk = ~core_clk;
  tlts_host u_host(.ser_data(ser_data), .ser_clk(ser_clk), .ser_latch(ser_latch));
  tlts_regs u_dut(.core_clk(core_clk), .rst(rst), .ser_data(ser_data), .ser_clk(ser_clk), .ser_latch(ser_latch),
    .tx_gain_code(g), .tx_vth_code(v), .tx_slope_code(s), .tx_imax_code(i), .tx_band_1900(band),
    .tx_ext_if_filter(ext), .tx_bb_bypass(byp), .tx_bb_std_unused(bbs), .rx_dll_en(dll), .uhf_doubler_en(dbl),
    .uhf_in_1900(uin), .fracn_comp_en(comp), .fracn_denom(den), .uhf_cp_code(uc), .rx_lo_low_side(ls),
    .rx_lo_div4(d4), .rx_pd_invert(inv), .rx_cp_code(rc));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", n, exp, got);
    end
  endtask
  // Output update is a fixed few cycles after the latch
  task automatic wr(input logic [23:0] w);
    u_host.send(w);
    repeat (10) @(negedge core_clk);
  endtask
  task automatic chk4(input logic [23:0] w);
    chk("tx", 24'({g, v, s, i, band, ext, bbs, byp}), 24'(w[15:4]));
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("den", 24'(den), 24'h5);
    wr(24'h03aa04);
    chk4(24'h03aa04);
    wr(24'hfffff6);
    chk4(24'h03aa04);
    wr(24'h13aac4);
    chk4(24'h13aac4);
    for (int c = 0; c < 4; c++) begin
      wr(24'(24'hd24005 | (c << 18) | (c << 7) | (c << 4)));
      chk("syn", 24'({rc, uc, den, ls, d4, inv, comp, dbl, uin}),
        24'({c[1:0], c[1:0], dt[c], 6'b101111}));
    end
    wr(24'h41aa04);
    chk4(24'h41aa04);
    chk("dbl", 24'({dbl, uin}), 24'h0);
    wr(24'h800074);
    chk4(24'h800074);
    chk("dll", 24'(dll), 24'h1);
    wr(24'h200005);
    chk("div4", 24'({dll, d4, comp}), 24'h2);
    finish_test();
  end
endmodule // tb
bind tlts_regs tlts_regs_sva u_sva(
  .core_clk(core_clk),
  .rst(rst),
  .ser_latch(ser_latch),
  .tx_gain_code(tx_gain_code),
  .tx_band_1900(tx_band_1900),
  .rx_dll_en(rx_dll_en),
  .rx_lo_div4(rx_lo_div4),
  .uhf_doubler_en(uhf_doubler_en),
  .uhf_in_1900(uhf_in_1900),
  .fracn_denom(fracn_denom),
  .uhf_cp_code(uhf_cp_code),
  .rx_cp_code(rx_cp_code)
);
`default_nettype wire
